// *** hw/io_map_pkg.sv ***
package io_map_pkg;

  localparam int          NREG         = 48;
  localparam int          IDX_W        = 6;
  localparam logic [7:0]  IO_DS_OFFSET = 8'h20;
  localparam logic [7:0]  RESET_VALUE  = 8'h00;

  // indices used by the checks
  localparam logic [5:0]  IDX_GPIO_B_IN   = 6'h00;
  localparam logic [5:0]  IDX_GPIO_B_OUT  = 6'h02;
  localparam logic [5:0]  IDX_TIMER0_FLAG = 6'h0F;
  localparam logic [5:0]  IDX_FAST_CTRL_A = 6'h12;

  // data-space address of each register, in index order
  localparam logic [7:0] REG_ADDR [NREG] = '{
    8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h29, 8'h2A,
    8'h2B, 8'h2C, 8'h2D, 8'h2E, 8'h2F, 8'h30, 8'h31, 8'h35,
    8'h36, 8'hBF, 8'hC0, 8'hC1, 8'hC2, 8'hC3, 8'hC4, 8'hC5,
    8'hC6, 8'hC7, 8'hC8, 8'hC9, 8'hCA, 8'hCB, 8'hCC, 8'hCD,
    8'hCE, 8'hCF, 8'hD0, 8'hD1, 8'hD2, 8'hD4, 8'hD7, 8'hD8,
    8'hD9, 8'hDA, 8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'hE4, 8'hE5
  };

  // bits held in flip-flops and written by software
  localparam logic [7:0] RW_MASK [NREG] = '{
    8'h00, 8'hFF, 8'hFF, 8'h00, 8'hC0, 8'hC0, 8'h00, 8'hFF,
    8'hFF, 8'h00, 8'h44, 8'h44, 8'h00, 8'hF3, 8'hF3, 8'h00,
    8'h00, 8'h07, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFD,
    8'hFF, 8'h00, 8'h03, 8'hFD, 8'hFF, 8'h03, 8'hFF, 8'h0F,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h01, 8'hB1,
    8'h00, 8'h00, 8'h0F, 8'h00, 8'h7F, 8'hFF, 8'h00, 8'h00
  };

  // sticky event flags, set by hardware, cleared by writing one
  localparam logic [7:0] W1C_MASK [NREG] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h07,
    8'h2F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h01, 8'h00, 8'h7F, 8'h00, 8'h00, 8'h00, 8'h00
  };

  // read-only bits that show a live hardware level
  localparam logic [7:0] HW_MASK [NREG] = '{
    8'hFF, 8'h00, 8'h00, 8'hC0, 8'h00, 8'h00, 8'hFF, 8'h00,
    8'h00, 8'h44, 8'h00, 8'h00, 8'hF3, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h03, 8'hBC, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h07
  };

endpackage

// *** hw/io_reg_bank.sv ***
`timescale 1ns/100ps

module io_reg_bank (
  input  wire logic        clk_sys_i,
  input  wire logic        srst_i,
  input  wire logic        io_rd_i,
  input  wire logic        io_wr_i,
  input  wire logic [5:0]  io_addr_i,
  input  wire logic        ds_rd_i,
  input  wire logic        ds_wr_i,
  input  wire logic [7:0]  ds_addr_i,
  input  wire logic        bit_set_i,
  input  wire logic        bit_clr_i,
  input  wire logic        tst_set_i,
  input  wire logic        tst_clr_i,
  input  wire logic [4:0]  bit_addr_i,
  input  wire logic [2:0]  bit_num_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic [7:0]  hw_level_i [io_map_pkg::NREG],
  input  wire logic [7:0]  hw_event_i [io_map_pkg::NREG],
  output logic      [7:0]  rdata_o,
  output logic             ack_o,
  output logic             err_o,
  output logic             skip_o,
  output logic      [7:0]  regs_o [io_map_pkg::NREG]
);

  // address search over the map; msb is the hit flag
  function automatic logic [6:0] find_index(input logic [7:0] addr);
    logic [6:0] res;
    res = 7'h00;
    for (int k = 0; k < io_map_pkg::NREG; k++) begin
      if (io_map_pkg::REG_ADDR[k] == addr) begin
        res = {1'b1, 6'(k)};
      end
    end
    return res;
  endfunction

  logic [7:0]  store_q [io_map_pkg::NREG];
  logic [7:0]  store_d [io_map_pkg::NREG];
  logic [7:0]  cur_w   [io_map_pkg::NREG];
  logic [7:0]  rdata_d;
  logic        ack_d;
  logic        err_d;
  logic        skip_d;

  wire         bit_op   = bit_set_i | bit_clr_i;
  wire         bit_tst  = tst_set_i | tst_clr_i;
  wire         bit_any  = bit_op | bit_tst;
  wire         io_sel   = !bit_any && (io_rd_i || io_wr_i);
  wire         ds_sel   = !bit_any && !io_sel && (ds_rd_i || ds_wr_i);
  wire         req_w    = bit_any | io_sel | ds_sel;

  // bit instructions carry only 5 address bits: window 0x00..0x1F
  wire  [7:0]  bit_da   = {3'h0, bit_addr_i} + io_map_pkg::IO_DS_OFFSET;
  // in/out carry 6 bits: I/O numbers 0x00..0x3F only
  wire  [7:0]  io_da    = {2'h0, io_addr_i} + io_map_pkg::IO_DS_OFFSET;
  // extended space is only reachable through the data-space port
  wire  [7:0]  acc_addr = bit_any ? bit_da : (io_sel ? io_da : ds_addr_i);

  wire  [6:0]  lookup   = find_index(acc_addr);
  wire         hit      = lookup[6];
  wire  [5:0]  idx      = lookup[5:0];
  wire  [7:0]  sel_val  = hit ? cur_w[idx] : 8'h00;
  wire  [7:0]  bit_mask = 8'h01 << bit_num_i;
  wire         sel_bit  = |(sel_val & bit_mask);

  wire         wr_req   = bit_op || (io_sel && io_wr_i) || (ds_sel && ds_wr_i);
  wire         wr_en    = hit && wr_req;

  // single-bit ops rebuild the full byte from what was read
  wire  [7:0]  bit_wv   = bit_set_i ? (sel_val | bit_mask) : (sel_val & ~bit_mask);
  wire  [7:0]  wv       = bit_op ? bit_wv : wdata_i;

  genvar gi;
  generate
    for (gi = 0; gi < io_map_pkg::NREG; gi++) begin : g_reg
      localparam logic [7:0] RW  = io_map_pkg::RW_MASK[gi];
      localparam logic [7:0] W1C = io_map_pkg::W1C_MASK[gi];
      localparam logic [7:0] HW  = io_map_pkg::HW_MASK[gi];

      wire        wr_hit = wr_en && (idx == 6'(gi));
      wire  [7:0] rw_nxt = (wr_hit ? wv : store_q[gi]) & RW;
      wire  [7:0] clr_w  = wr_hit ? (wv & W1C) : 8'h00;
      // hardware set wins over a same-cycle clear
      wire  [7:0] fl_nxt = (store_q[gi] & W1C & ~clr_w) | (hw_event_i[gi] & W1C);

      // reserved bits are neither stored nor driven: they read as zero
      assign cur_w[gi]   = (store_q[gi] & (RW | W1C)) | (hw_level_i[gi] & HW);
      assign store_d[gi] = rw_nxt | fl_nxt;
      assign regs_o[gi]  = store_q[gi];

      always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
          store_q[gi] <= io_map_pkg::RESET_VALUE;
        end else begin
          store_q[gi] <= store_d[gi];
        end
      end
    end
  endgenerate

  // answer path: one cycle after the request
  assign ack_d   = req_w;
  assign err_d   = req_w && !hit;
  assign rdata_d = (req_w && !bit_op && !bit_tst) ? sel_val : 8'h00;
  assign skip_d  = tst_set_i ? sel_bit : (tst_clr_i && hit && !sel_bit);

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      rdata_o <= 8'h00;
      ack_o   <= 1'b0;
      err_o   <= 1'b0;
      skip_o  <= 1'b0;
    end else begin
      rdata_o <= rdata_d;
      ack_o   <= ack_d;
      err_o   <= err_d;
      skip_o  <= skip_d;
    end
  end

  // ---- checks ----

  wire [7:0] t0_flags = regs_o[io_map_pkg::IDX_TIMER0_FLAG];
  wire [7:0] pb_out   = regs_o[io_map_pkg::IDX_GPIO_B_OUT];
  wire [7:0] ctrl_a   = regs_o[io_map_pkg::IDX_FAST_CTRL_A];
  wire       only_io  = !bit_any && !ds_rd_i && !ds_wr_i;
  wire       only_ds  = !bit_any && !io_rd_i && !io_wr_i;
  wire       no_t0ev  = (hw_event_i[io_map_pkg::IDX_TIMER0_FLAG] == 8'h00);
  wire       any_req  = bit_any | io_rd_i | io_wr_i | ds_rd_i | ds_wr_i;
  // timer0 holds three flags
  wire [7:0] t0_ev    = hw_event_i[io_map_pkg::IDX_TIMER0_FLAG] & 8'h07;

  property p_w1c_clear;
    @(posedge clk_sys_i) disable iff (srst_i)
      io_wr_i && only_io && io_addr_i == 6'h15 && wdata_i[0] && no_t0ev
      |=> !t0_flags[0];
  endproperty
  a_w1c_clear: assert property (p_w1c_clear)
    else $error("flag not cleared by writing one");

  property p_w1c_zero_keeps;
    @(posedge clk_sys_i) disable iff (srst_i)
      io_wr_i && only_io && io_addr_i == 6'h15 && !wdata_i[1]
      |=> t0_flags[1] == $past(t0_flags[1]) || $past(hw_event_i[15][1]);
  endproperty
  a_w1c_zero_keeps: assert property (p_w1c_zero_keeps)
    else $error("flag changed by writing zero");

  property p_event_wins;
    @(posedge clk_sys_i) disable iff (srst_i)
      hw_event_i[15][2] |=> t0_flags[2] ##1 (t0_flags[2] || $past(wr_en));
  endproperty
  a_event_wins: assert property (p_event_wins)
    else $error("hardware event lost");

  property p_set_bit;
    @(posedge clk_sys_i) disable iff (srst_i)
      bit_set_i && bit_addr_i == 5'h05
      |=> pb_out == ($past(pb_out) | (8'h01 << $past(bit_num_i)));
  endproperty
  a_set_bit: assert property (p_set_bit)
    else $error("set-bit did not set exactly one bit");

  property p_clr_bit;
    @(posedge clk_sys_i) disable iff (srst_i)
      bit_clr_i && !bit_set_i && bit_addr_i == 5'h05
      |=> pb_out == ($past(pb_out) & ~(8'h01 << $past(bit_num_i)));
  endproperty
  a_clr_bit: assert property (p_clr_bit)
    else $error("clear-bit did not clear exactly one bit");

  property p_rmw_clears_flags;
    @(posedge clk_sys_i) disable iff (srst_i)
      (bit_set_i || bit_clr_i) && bit_addr_i == 5'h15 && no_t0ev
      |=> t0_flags == ($past(bit_set_i) ? 8'h00
                       : ($past(t0_flags) & (8'h01 << $past(bit_num_i))));
  endproperty
  a_rmw_clears_flags: assert property (p_rmw_clears_flags)
    else $error("bit op did not rewrite flags read as set");

  property p_skip_test;
    @(posedge clk_sys_i) disable iff (srst_i)
      tst_set_i && bit_addr_i == 5'h03
      |=> ack_o && skip_o == $past(hw_level_i[0][bit_num_i]);
  endproperty
  a_skip_test: assert property (p_skip_test)
    else $error("skip result does not match tested bit");

  property p_io_pin_read;
    @(posedge clk_sys_i) disable iff (srst_i)
      io_rd_i && only_io && io_addr_i == 6'h03
      |=> rdata_o == $past(hw_level_i[io_map_pkg::IDX_GPIO_B_IN]) && !err_o;
  endproperty
  a_io_pin_read: assert property (p_io_pin_read)
    else $error("I/O read of pin level wrong");

  property p_ds_offset;
    @(posedge clk_sys_i) disable iff (srst_i)
      ds_rd_i && only_ds && ds_addr_i == 8'h25
      |=> ack_o && !err_o && rdata_o == $past(pb_out);
  endproperty
  a_ds_offset: assert property (p_ds_offset)
    else $error("data-space view not at I/O number plus offset");

  property p_ext_store;
    @(posedge clk_sys_i) disable iff (srst_i)
      ds_wr_i && only_ds && ds_addr_i == 8'hC0
      |=> ctrl_a == $past(wdata_i) ##1 ctrl_a == $past(ctrl_a) || $past(wr_en);
  endproperty
  a_ext_store: assert property (p_ext_store)
    else $error("extended register store failed");

  property p_io_no_ext;
    @(posedge clk_sys_i) disable iff (srst_i)
      io_wr_i && only_io |=> ctrl_a == $past(ctrl_a);
  endproperty
  a_io_no_ext: assert property (p_io_no_ext)
    else $error("I/O write reached extended register");

  property p_unmapped_err;
    @(posedge clk_sys_i) disable iff (srst_i)
      io_rd_i && only_io && io_addr_i == 6'h00
      |=> ack_o && err_o && rdata_o == 8'h00;
  endproperty
  a_unmapped_err: assert property (p_unmapped_err)
    else $error("reserved location not answered as unmapped");

  property p_bit_op_no_data;
    @(posedge clk_sys_i) disable iff (srst_i)
      bit_set_i || bit_clr_i |=> ack_o && rdata_o == 8'h00;
  endproperty
  a_bit_op_no_data: assert property (p_bit_op_no_data)
    else $error("bit op returned read data");

  property p_bit_set_port_d;
    @(posedge clk_sys_i) disable iff (srst_i)
      bit_set_i && bit_addr_i == 5'h0B
      |=> regs_o[8] == ($past(regs_o[8]) | (8'h01 << $past(bit_num_i)));
  endproperty
  a_bit_set_port_d: assert property (p_bit_set_port_d)
    else $error("set-bit on port d latch wrong");

  property p_bit_op_keeps_others;
    @(posedge clk_sys_i) disable iff (srst_i)
      (bit_set_i || bit_clr_i) && bit_addr_i == 5'h05
      |=> regs_o[1] == $past(regs_o[1]) && regs_o[8] == $past(regs_o[8]);
  endproperty
  a_bit_op_keeps_others: assert property (p_bit_op_keeps_others)
    else $error("bit op touched another register");

  property p_test_reserved_err;
    @(posedge clk_sys_i) disable iff (srst_i)
      (tst_set_i || tst_clr_i) && bit_addr_i == 5'h00 |=> ack_o && err_o && !skip_o;
  endproperty
  a_test_reserved_err: assert property (p_test_reserved_err)
    else $error("bit test of reserved location not refused");

  property p_skip_clear;
    @(posedge clk_sys_i) disable iff (srst_i)
      tst_clr_i && !tst_set_i && bit_addr_i == 5'h03
      |=> ack_o && skip_o == !$past(hw_level_i[0][bit_num_i]);
  endproperty
  a_skip_clear: assert property (p_skip_clear)
    else $error("skip-if-clear result wrong");

  property p_test_no_write;
    @(posedge clk_sys_i) disable iff (srst_i)
      (tst_set_i || tst_clr_i) && !bit_set_i && !bit_clr_i
      |=> pb_out == $past(pb_out) && ctrl_a == $past(ctrl_a);
  endproperty
  a_test_no_write: assert property (p_test_no_write)
    else $error("bit test changed a register");

  property p_test_reads_latch;
    @(posedge clk_sys_i) disable iff (srst_i)
      tst_set_i && bit_addr_i == 5'h05 |=> skip_o == $past(pb_out[bit_num_i]);
  endproperty
  a_test_reads_latch: assert property (p_test_reads_latch)
    else $error("skip-if-set on latch wrong");

  property p_skip_only_tests;
    @(posedge clk_sys_i) disable iff (srst_i)
      !tst_set_i && !tst_clr_i |=> !skip_o;
  endproperty
  a_skip_only_tests: assert property (p_skip_only_tests)
    else $error("skip raised without a bit test");

  property p_test_no_data;
    @(posedge clk_sys_i) disable iff (srst_i)
      tst_set_i || tst_clr_i |=> ack_o && rdata_o == 8'h00;
  endproperty
  a_test_no_data: assert property (p_test_no_data)
    else $error("bit test returned read data");

  property p_w1c_ds_clear;
    @(posedge clk_sys_i) disable iff (srst_i)
      ds_wr_i && only_ds && ds_addr_i == 8'h35 && no_t0ev
      |=> t0_flags == ($past(t0_flags) & ~$past(wdata_i));
  endproperty
  a_w1c_ds_clear: assert property (p_w1c_ds_clear)
    else $error("store to flags did not clear exactly the ones written");

  property p_flag_holds;
    @(posedge clk_sys_i) disable iff (srst_i)
      !io_wr_i && !ds_wr_i && !bit_set_i && !bit_clr_i && no_t0ev
      |=> t0_flags == $past(t0_flags);
  endproperty
  a_flag_holds: assert property (p_flag_holds)
    else $error("flags changed without write or event");

  property p_event_sets;
    @(posedge clk_sys_i) disable iff (srst_i)
      t0_ev != 8'h00 |=> (t0_flags & $past(t0_ev)) == $past(t0_ev);
  endproperty
  a_event_sets: assert property (p_event_sets)
    else $error("hardware event did not set its flag");

  property p_io_write_lands;
    @(posedge clk_sys_i) disable iff (srst_i)
      io_wr_i && only_io && io_addr_i == 6'h05 |=> pb_out == $past(wdata_i);
  endproperty
  a_io_write_lands: assert property (p_io_write_lands)
    else $error("I/O write did not land");

  property p_io_high_unmapped;
    @(posedge clk_sys_i) disable iff (srst_i)
      (io_rd_i || io_wr_i) && only_io && io_addr_i == 6'h3F
      |=> ack_o && err_o && rdata_o == 8'h00;
  endproperty
  a_io_high_unmapped: assert property (p_io_high_unmapped)
    else $error("top I/O number not answered as unmapped");

  property p_ds_pin_view;
    @(posedge clk_sys_i) disable iff (srst_i)
      ds_rd_i && only_ds && ds_addr_i == 8'h23
      |=> ack_o && rdata_o == $past(hw_level_i[io_map_pkg::IDX_GPIO_B_IN]);
  endproperty
  a_ds_pin_view: assert property (p_ds_pin_view)
    else $error("data-space pin level view wrong");

  property p_ds_below_window;
    @(posedge clk_sys_i) disable iff (srst_i)
      (ds_rd_i || ds_wr_i) && only_ds && ds_addr_i == 8'h22
      |=> ack_o && err_o && rdata_o == 8'h00;
  endproperty
  a_ds_below_window: assert property (p_ds_below_window)
    else $error("reserved data address not answered as unmapped");

  property p_bit_no_ext;
    @(posedge clk_sys_i) disable iff (srst_i)
      bit_set_i || bit_clr_i |=> ctrl_a == $past(ctrl_a);
  endproperty
  a_bit_no_ext: assert property (p_bit_no_ext)
    else $error("bit op reached extended register");

  property p_ext_load;
    @(posedge clk_sys_i) disable iff (srst_i)
      ds_rd_i && only_ds && ds_addr_i == 8'hC0 |=> rdata_o == $past(ctrl_a) && !err_o;
  endproperty
  a_ext_load: assert property (p_ext_load)
    else $error("extended register load wrong");

  property p_idle_no_answer;
    @(posedge clk_sys_i) disable iff (srst_i)
      !any_req |=> !ack_o && !err_o && rdata_o == 8'h00;
  endproperty
  a_idle_no_answer: assert property (p_idle_no_answer)
    else $error("answer without a request");

  property p_io_read_no_write;
    @(posedge clk_sys_i) disable iff (srst_i)
      io_rd_i && !io_wr_i && only_io |=> pb_out == $past(pb_out);
  endproperty
  a_io_read_no_write: assert property (p_io_read_no_write)
    else $error("I/O read changed a register");

endmodule

// *** tb/core_model.sv ***
`timescale 1ns/100ps

module core_model (
  input  wire logic       clk_sys_i,
  input  wire logic       ack_i,
  input  wire logic       err_i,
  input  wire logic       skip_i,
  input  wire logic [7:0] rdata_i,
  output logic            io_rd_o,
  output logic            io_wr_o,
  output logic      [5:0] io_addr_o,
  output logic            ds_rd_o,
  output logic            ds_wr_o,
  output logic      [7:0] ds_addr_o,
  output logic            bit_set_o,
  output logic            bit_clr_o,
  output logic            tst_set_o,
  output logic            tst_clr_o,
  output logic      [4:0] bit_addr_o,
  output logic      [2:0] bit_num_o,
  output logic      [7:0] wdata_o
);
  initial begin
    {io_rd_o, io_wr_o, ds_rd_o, ds_wr_o} = 4'h0;
    {bit_set_o, bit_clr_o, tst_set_o, tst_clr_o} = 4'h0;
    {io_addr_o, ds_addr_o, bit_addr_o, bit_num_o, wdata_o} = 30'h0;
  end

  // kinds: 0 io rd, 1 io wr, 2 ds rd, 3 ds wr, 4 set, 5 clr, 6 test set, 7 test clr
  task automatic op(input int k, input logic [7:0] a, input logic [7:0] d,
                    input logic [2:0] b, output logic [7:0] rd, output logic er,
                    output logic sk, output logic got);
    @(negedge clk_sys_i);
    {io_rd_o, io_wr_o, ds_rd_o, ds_wr_o} = {k == 0, k == 1, k == 2, k == 3};
    {bit_set_o, bit_clr_o, tst_set_o, tst_clr_o} = {k == 4, k == 5, k == 6, k == 7};
    io_addr_o  = a[5:0];
    ds_addr_o  = a;
    bit_addr_o = a[4:0];
    bit_num_o  = b;
    wdata_o    = d;
    @(negedge clk_sys_i);
    {io_rd_o, io_wr_o, ds_rd_o, ds_wr_o} = 4'h0;
    {bit_set_o, bit_clr_o, tst_set_o, tst_clr_o} = 4'h0;
    wdata_o = ~d;
    got = 1'b0;
    for (int n = 0; n < 4 && !got; n++) begin
      if (ack_i === 1'b1) begin
        got = 1'b1;
        rd  = rdata_i;
        er  = err_i;
        sk  = skip_i;
      end else begin
        @(negedge clk_sys_i);
      end
    end
  endtask
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/100ps

module testbench;
  typedef struct {int k; logic [7:0] a; logic [7:0] d; logic [2:0] b;
                  logic [7:0] rd; logic er; logic sk;} row_t;
  logic       clk_sys_i = 1'b0;
  logic       srst_i    = 1'b1;
  logic       io_rd, io_wr, ds_rd, ds_wr, b_set, b_clr, t_set, t_clr, ack, err, skip;
  logic [5:0] io_addr;
  logic [7:0] ds_addr, wdata, rdata;
  logic [4:0] bit_addr;
  logic [2:0] bit_num;
  logic [7:0] lvl  [io_map_pkg::NREG];
  logic [7:0] evt  [io_map_pkg::NREG];
  logic [7:0] regs [io_map_pkg::NREG];
  int         err_total    = 0;
  int         total_checks = 0;
  row_t       t [21] = '{
    '{1, 8'h05, 8'hA5, 3'h0, 8'h00, 1'b0, 1'b0}, '{2, 8'h25, 8'h00, 3'h0, 8'hA5, 1'b0, 1'b0},
    '{3, 8'hC0, 8'h3C, 3'h0, 8'h00, 1'b0, 1'b0}, '{2, 8'hC0, 8'h00, 3'h0, 8'h3C, 1'b0, 1'b0},
    '{0, 8'h3F, 8'h00, 3'h0, 8'h00, 1'b1, 1'b0}, '{0, 8'h03, 8'h00, 3'h0, 8'h5A, 1'b0, 1'b0},
    '{4, 8'h05, 8'h00, 3'h1, 8'h00, 1'b0, 1'b0}, '{5, 8'h05, 8'h00, 3'h7, 8'h00, 1'b0, 1'b0},
    '{0, 8'h05, 8'h00, 3'h0, 8'h27, 1'b0, 1'b0}, '{6, 8'h03, 8'h00, 3'h1, 8'h00, 1'b0, 1'b1},
    '{7, 8'h03, 8'h00, 3'h1, 8'h00, 1'b0, 1'b0}, '{7, 8'h03, 8'h00, 3'h0, 8'h00, 1'b0, 1'b1},
    '{6, 8'h03, 8'h00, 3'h0, 8'h00, 1'b0, 1'b0}, '{0, 8'h00, 8'h00, 3'h0, 8'h00, 1'b1, 1'b0},
    '{2, 8'h22, 8'h00, 3'h0, 8'h00, 1'b1, 1'b0}, '{6, 8'h05, 8'h00, 3'h0, 8'h00, 1'b0, 1'b1},
    '{6, 8'h00, 8'h00, 3'h0, 8'h00, 1'b1, 1'b0}, '{4, 8'h0B, 8'h00, 3'h3, 8'h00, 1'b0, 1'b0},
    '{2, 8'h2B, 8'h00, 3'h0, 8'h08, 1'b0, 1'b0}, '{2, 8'h23, 8'h00, 3'h0, 8'h5A, 1'b0, 1'b0},
    '{7, 8'h00, 8'h00, 3'h0, 8'h00, 1'b1, 1'b0}};

  always #25 clk_sys_i = ~clk_sys_i;

  io_reg_bank u_dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .io_rd_i(io_rd), .io_wr_i(io_wr),
    .io_addr_i(io_addr), .ds_rd_i(ds_rd), .ds_wr_i(ds_wr), .ds_addr_i(ds_addr),
    .bit_set_i(b_set), .bit_clr_i(b_clr), .tst_set_i(t_set), .tst_clr_i(t_clr),
    .bit_addr_i(bit_addr), .bit_num_i(bit_num), .wdata_i(wdata), .hw_level_i(lvl),
    .hw_event_i(evt), .rdata_o(rdata), .ack_o(ack), .err_o(err), .skip_o(skip), .regs_o(regs));

  core_model u_core (.clk_sys_i(clk_sys_i), .ack_i(ack), .err_i(err), .skip_i(skip),
    .rdata_i(rdata), .io_rd_o(io_rd), .io_wr_o(io_wr), .io_addr_o(io_addr), .ds_rd_o(ds_rd),
    .ds_wr_o(ds_wr), .ds_addr_o(ds_addr), .bit_set_o(b_set), .bit_clr_o(b_clr),
    .tst_set_o(t_set), .tst_clr_o(t_clr), .bit_addr_o(bit_addr), .bit_num_o(bit_num),
    .wdata_o(wdata));

  task automatic summarize();
    if (err_total == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic do_row(input row_t r);
    logic [7:0] rd;
    logic       er, sk, got;
    u_core.op(r.k, r.a, r.d, r.b, rd, er, sk, got);
    chk1(got, 1'b1);
    if (got !== 1'b1) summarize();
    chk8(rd, r.rd);
    chk1(er, r.er);
    chk1(sk, r.sk);
  endtask

  // one-cycle hardware event pulse
  task automatic ev(input int i, input logic [7:0] v);
    @(negedge clk_sys_i);
    evt[i] = v;
    @(negedge clk_sys_i);
    evt[i] = 8'h00;
  endtask

  initial begin
    for (int i = 0; i < io_map_pkg::NREG; i++) begin
      lvl[i] = 8'h00;
      evt[i] = 8'h00;
    end
    lvl[io_map_pkg::IDX_GPIO_B_IN] = 8'h5A;
    repeat (10) @(negedge clk_sys_i);
    srst_i = 1'b0;
    chk8(regs[io_map_pkg::IDX_GPIO_B_OUT], 8'h00);
    chk1(ack, 1'b0);
    for (int i = 0; i < 21; i++) do_row(t[i]);
    chk8(regs[io_map_pkg::IDX_FAST_CTRL_A], 8'h3C);
    ev(io_map_pkg::IDX_TIMER0_FLAG, 8'h03);
    do_row('{2, 8'h35, 8'h00, 3'h0, 8'h03, 1'b0, 1'b0});
    do_row('{3, 8'h35, 8'h00, 3'h0, 8'h03, 1'b0, 1'b0});
    do_row('{2, 8'h35, 8'h00, 3'h0, 8'h03, 1'b0, 1'b0});
    do_row('{3, 8'h35, 8'h01, 3'h0, 8'h03, 1'b0, 1'b0});
    do_row('{0, 8'h15, 8'h00, 3'h0, 8'h02, 1'b0, 1'b0});
    ev(io_map_pkg::IDX_TIMER0_FLAG, 8'h01);
    do_row('{5, 8'h15, 8'h00, 3'h2, 8'h00, 1'b0, 1'b0});
    do_row('{2, 8'h35, 8'h00, 3'h0, 8'h00, 1'b0, 1'b0});
    @(negedge clk_sys_i);
    srst_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    srst_i = 1'b0;
    chk8(regs[io_map_pkg::IDX_GPIO_B_OUT], 8'h00);
    chk8(regs[io_map_pkg::IDX_FAST_CTRL_A], 8'h00);
    summarize();
  end
endmodule
